//--- src/srs_pkg.sv
package srs_pkg;
	localparam int SRC_W = 8;
	localparam int MOD_W = 5;
	localparam int PORT_W = 16;
	localparam int APB_W = 16;
	localparam logic [31:0] BOOT_ADDR = 32'h0000_0000;
	// peripheral clock enable positions kept on during reset
	localparam int APB_WDT_BIT = 0;
	localparam int APB_XBAR_BIT = 1;
	// selectable module reset positions
	localparam int MOD_CPUMP = 0;
	localparam int MOD_SERIAL = 1;
	localparam int MOD_DISPLAY = 2;
	localparam int MOD_CAPTURE = 3;
	localparam int MOD_CAL = 4;
	// source vector positions driving the reset pin low
	localparam int SRC_POR = 0;
	localparam int SRC_SUPPLY = 1;
	localparam logic [1:0] SYSCLK_LPOSC = 2'h0;
	localparam logic [1:0] WDTCLK_LFOSC = 2'h1;
	localparam logic [SRC_W-1:0] SRC_EN_RST = 8'hFF;
	localparam logic [SRC_W-1:0] SRC_POR_MASK = 8'h03;

	typedef enum {ST_RUN, ST_RESET, ST_EXIT} srs_state_t;

	typedef struct packed {
		logic core_halt;
		logic [31:0] pc_load;
		logic pc_load_en;
		logic [1:0] sysclk_sel;
		logic wdt_en;
		logic [1:0] wdt_clk_sel;
	} srs_core_t;

	typedef struct packed {
		logic [PORT_W-1:0] latch_one;
		logic open_drain;
		logic pullup_en;
		logic rst_pin_out;
		logic rst_pin_oe;
	} srs_pins_t;

	typedef struct packed {
		logic sys_rst;
		logic por_rst;
		logic irq_disable;
		logic timer_disable;
		logic ahb_flash_clk;
		logic ahb_ram_clk;
		logic [APB_W-1:0] apb_clk_force_off;
		logic [MOD_W-1:0] mod_rst;
	} srs_ctl_t;
endpackage : srs_pkg

//--- src/srs_top.sv
module srs_top
	import srs_pkg::*;
(
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [SRC_W-1:0] src_req,
	input wire logic supply_below_thr,
	input wire logic clock_reset_lock_bit,
	input wire logic src_wr,
	input wire logic [SRC_W-1:0] src_wr_enable,
	input wire logic [SRC_W-1:0] src_wr_modsel,
	input wire logic [SRC_W-1:0] src_wr_modmap,
	output srs_core_t core,
	output srs_pins_t pins,
	output srs_ctl_t ctl,
	output logic [SRC_W-1:0] src_enable,
	output logic [SRC_W-1:0] src_last,
	output logic reset_active
);
	typedef struct packed {
		srs_state_t st;
		srs_core_t core;
		srs_pins_t pins;
		srs_ctl_t ctl;
		logic [SRC_W-1:0] en;
		logic [SRC_W-1:0] modsel;
		logic [SRC_W-1:0] last;
		logic act;
	} srs_s_t;

	srs_s_t s;
	srs_s_t next_s;
	logic [SRC_W-1:0] live;
	logic pin_low_src;

	always_comb begin
		// supply hold
		// supply level counts as a source even if its enable is cleared
		live = src_req & s.en;
		live[SRC_SUPPLY] = live[SRC_SUPPLY] | supply_below_thr;
		live[SRC_POR] = src_req[SRC_POR];
		pin_low_src = |(live & SRC_POR_MASK);
	end

	always_comb begin
		next_s = s;
		next_s.core.pc_load_en = 1'b0;
		if (src_wr && !clock_reset_lock_bit) begin
			next_s.en = src_wr_enable;
			next_s.modsel = src_wr_modmap & src_wr_modsel;
		end
		unique case (s.st)
			ST_RUN: begin
				if (|live) begin
					next_s.st = ST_RESET;
				end
			end
			ST_RESET: begin
				if (!(|live)) begin
					next_s.st = ST_EXIT;
				end
			end
			ST_EXIT: begin
				next_s.st = (|live) ? ST_RESET : ST_RUN;
			end
		endcase
		if (next_s.st == ST_RESET) begin
			next_s.act = 1'b1;
			next_s.last = s.last | live;
			next_s.core.core_halt = 1'b1;
			next_s.ctl.sys_rst = 1'b1;
			next_s.ctl.por_rst = live[SRC_POR];
			next_s.pins.latch_one = '1;
			next_s.pins.open_drain = 1'b1;
			next_s.ctl.irq_disable = 1'b1;
			next_s.ctl.timer_disable = 1'b1;
			next_s.ctl.ahb_flash_clk = 1'b1;
			next_s.ctl.ahb_ram_clk = 1'b1;
			next_s.ctl.apb_clk_force_off = '1;
			next_s.ctl.apb_clk_force_off[APB_WDT_BIT] = 1'b0;
			next_s.ctl.apb_clk_force_off[APB_XBAR_BIT] = 1'b0;
			next_s.ctl.mod_rst = (|(live & s.modsel)) ? '1 : '0;
			if (pin_low_src) begin
				next_s.pins.rst_pin_oe = 1'b1;
			end
			next_s.pins.rst_pin_out = 1'b0;
		end else if (s.st == ST_RESET) begin
			next_s.act = 1'b0;
			next_s.core.core_halt = 1'b0;
			next_s.ctl = '0;
			next_s.ctl.ahb_flash_clk = 1'b1;
			next_s.ctl.ahb_ram_clk = 1'b1;
			next_s.pins.rst_pin_oe = 1'b0;
			next_s.core.pc_load = BOOT_ADDR;
			next_s.core.pc_load_en = 1'b1;
			next_s.core.sysclk_sel = SYSCLK_LPOSC;
			next_s.core.wdt_en = 1'b1;
			next_s.core.wdt_clk_sel = WDTCLK_LFOSC;
		end
		next_s.pins.pullup_en = 1'b1;
		// no ram port: ram is never written here
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
			s.st <= ST_RESET;
			s.act <= 1'b1;
			s.en <= SRC_EN_RST;
			s.core.core_halt <= 1'b1;
			s.ctl.sys_rst <= 1'b1;
			s.ctl.por_rst <= 1'b1;
			s.ctl.irq_disable <= 1'b1;
			s.ctl.timer_disable <= 1'b1;
			s.ctl.ahb_flash_clk <= 1'b1;
			s.ctl.ahb_ram_clk <= 1'b1;
			s.ctl.apb_clk_force_off <= 16'hFFFC;
			s.ctl.mod_rst <= 5'h1F;
			s.pins.latch_one <= 16'hFFFF;
			s.pins.open_drain <= 1'b1;
			s.pins.pullup_en <= 1'b1;
			s.pins.rst_pin_oe <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign core = s.core;
	assign pins = s.pins;
	assign ctl = s.ctl;
	assign src_enable = s.en;
	assign src_last = s.last;
	assign reset_active = s.act;

	property p_halt;
		@(posedge mclk) disable iff (!arst_n)
		(|live) |=> core.core_halt;
	endproperty
	a_halt: assert property (p_halt) else $error("core not halted");
	property p_pin;
		@(posedge mclk) disable iff (!arst_n)
		pin_low_src |=> pins.rst_pin_oe && !pins.rst_pin_out;
	endproperty
	a_pin: assert property (p_pin) else $error("reset pin not low");
	sequence s_leave;
		reset_active ##1 !reset_active;
	endsequence
	property p_exit;
		@(posedge mclk) disable iff (!arst_n)
		s_leave |-> core.pc_load_en && core.pc_load == BOOT_ADDR
			&& core.wdt_en && core.sysclk_sel == SYSCLK_LPOSC;
	endproperty
	a_exit: assert property (p_exit) else $error("bad exit");
	property p_lock;
		@(posedge mclk) disable iff (!arst_n)
		(src_wr && clock_reset_lock_bit) |=> $stable(src_enable);
	endproperty
	a_lock: assert property (p_lock) else $error("locked write took");
	property p_apb;
		@(posedge mclk) disable iff (!arst_n)
		reset_active |-> !ctl.apb_clk_force_off[APB_WDT_BIT]
			&& !ctl.apb_clk_force_off[APB_XBAR_BIT]
			&& ctl.apb_clk_force_off[2] && ctl.ahb_ram_clk;
	endproperty
	a_apb: assert property (p_apb) else $error("clock gating wrong");
	property p_hold;
		@(posedge mclk) disable iff (!arst_n)
		supply_below_thr |=> reset_active;
	endproperty
	a_hold: assert property (p_hold) else $error("supply hold lost");
	property p_pull;
		@(posedge mclk) disable iff (!arst_n)
		pins.pullup_en && (!reset_active || (&pins.latch_one));
	endproperty
	a_pull: assert property (p_pull) else $error("pins wrong");
	property p_irq;
		@(posedge mclk) disable iff (!arst_n)
		reset_active |-> ctl.irq_disable && ctl.timer_disable;
	endproperty
	a_irq: assert property (p_irq) else $error("irq not off");
	property p_ports;
		@(posedge mclk) disable iff (!arst_n)
		reset_active |-> pins.open_drain && (&pins.latch_one);
	endproperty
	a_ports: assert property (p_ports) else $error("ports not forced");
	property p_fast;
		@(posedge mclk) disable iff (!arst_n)
		reset_active |-> ctl.ahb_flash_clk && ctl.ahb_ram_clk;
	endproperty
	a_fast: assert property (p_fast) else $error("fast clocks off");
	property p_por;
		@(posedge mclk) disable iff (!arst_n)
		live[SRC_POR] |=> ctl.por_rst && ctl.sys_rst;
	endproperty
	a_por: assert property (p_por) else $error("power-on reset lost");
	property p_wdt;
		@(posedge mclk) disable iff (!arst_n)
		s_leave |-> core.wdt_en && core.wdt_clk_sel == WDTCLK_LFOSC;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not set");
	property p_modrst;
		@(posedge mclk) disable iff (!arst_n)
		(|(live & s.modsel)) |=> (&ctl.mod_rst);
	endproperty
	a_modrst: assert property (p_modrst) else $error("module reset lost");
	property p_stay;
		@(posedge mclk) disable iff (!arst_n)
		(reset_active && (|live)) |=> reset_active;
	endproperty
	a_stay: assert property (p_stay) else $error("reset left early");
endmodule : srs_top

//--- test/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import srs_pkg::*;
	logic mclk, arst_n, supply_below_thr, clock_reset_lock_bit, src_wr;
	logic [SRC_W-1:0] src_req, src_wr_enable, src_wr_modsel, src_wr_modmap;
	srs_core_t core;
	srs_pins_t pins;
	srs_ctl_t ctl;
	logic [SRC_W-1:0] src_enable, src_last;
	logic reset_active;
	int bad_count, checks_done, cyc;

	srs_top uut (.mclk(mclk), .arst_n(arst_n), .src_req(src_req),
		.supply_below_thr(supply_below_thr),
		.clock_reset_lock_bit(clock_reset_lock_bit), .src_wr(src_wr),
		.src_wr_enable(src_wr_enable), .src_wr_modsel(src_wr_modsel),
		.src_wr_modmap(src_wr_modmap), .core(core), .pins(pins),
		.ctl(ctl), .src_enable(src_enable), .src_last(src_last),
		.reset_active(reset_active));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish

	// hang guard, whole run is well under a thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic chk_held(input logic pin);
		chk(reset_active, 1);
		chk(core.core_halt, 1);
		chk(ctl.sys_rst, 1);
		chk(pins.latch_one, 32'h0000FFFF);
		chk(pins.open_drain, 1);
		chk(pins.pullup_en, 1);
		chk({ctl.irq_disable, ctl.timer_disable}, 2'h3);
		chk({ctl.ahb_flash_clk, ctl.ahb_ram_clk}, 2'h3);
		chk(ctl.apb_clk_force_off, 16'hFFFC);
		chk(pins.rst_pin_oe, pin);
		if (pin)
			chk(pins.rst_pin_out, 0);
	endtask : chk_held

	task automatic chk_exit;
		chk(reset_active, 0);
		chk(core.pc_load_en, 1);
		chk(core.pc_load, BOOT_ADDR);
		chk(core.sysclk_sel, SYSCLK_LPOSC);
		chk({core.wdt_en, core.wdt_clk_sel}, {1'b1, WDTCLK_LFOSC});
		chk(pins.pullup_en, 1);
		@(posedge mclk);
		#1;
		chk({core.pc_load_en, core.core_halt}, 2'h0);
	endtask : chk_exit

	// source checked after hold cycles, dropped one cycle later; mod checked on plain sources
	task automatic run_src(input logic [SRC_W-1:0] req, input logic sup,
		input int hold, input logic pin, input logic [MOD_W-1:0] mod);
		@(posedge mclk);
		src_req <= req;
		supply_below_thr <= sup;
		repeat (hold) @(posedge mclk);
		#1;
		chk_held(pin);
		chk(ctl.por_rst, req[SRC_POR]);
		if (!pin)
			chk(ctl.mod_rst, mod);
		@(posedge mclk);
		src_req <= '0;
		supply_below_thr <= 1'b0;
		@(posedge mclk);
		#1;
		chk_exit();
		$display("test source %h done", req);
	endtask : run_src

	task automatic wr(input logic [SRC_W-1:0] en, input logic [SRC_W-1:0] sel,
		input logic [SRC_W-1:0] map, input logic lock);
		@(posedge mclk);
		{src_wr, src_wr_enable, src_wr_modsel} <= {1'b1, en, sel};
		src_wr_modmap <= map;
		clock_reset_lock_bit <= lock;
		@(posedge mclk);
		src_wr <= 1'b0;
		@(posedge mclk);
		clock_reset_lock_bit <= 1'b0;
		#1;
	endtask : wr

	initial begin
		{arst_n, supply_below_thr, clock_reset_lock_bit, src_wr} = 4'h0;
		{src_req, src_wr_modsel, src_wr_modmap} = '0;
		src_wr_enable = 8'hFF;
		repeat (2) @(posedge mclk);
		#1;
		chk_held(1);
		chk(src_enable, SRC_EN_RST);
		chk(ctl.por_rst, 1);
		@(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		#1;
		chk_exit();
		$display("test power-on done");
		// long supply dip keeps reset up all the way
		run_src('0, 1'b1, 40, 1'b1, '0);
		run_src(8'h01, 1'b0, 3, 1'b1, '0);
		chk(src_last[SRC_POR], 1);
		wr(8'hFF, 8'h04, 8'h04, 1'b0);
		run_src(8'h04, 1'b0, 3, 1'b0, 5'h1F);
		run_src(8'h08, 1'b0, 2, 1'b0, 5'h00);
		// module map clear: a selected source resets no module
		wr(8'hFF, 8'h04, 8'h00, 1'b0);
		run_src(8'h04, 1'b0, 2, 1'b0, 5'h00);
		// masked source must not start a reset
		wr(8'hFB, 8'h00, 8'h00, 1'b0);
		chk(src_enable, 8'hFB);
		@(posedge mclk);
		src_req <= 8'h04;
		repeat (4) @(posedge mclk);
		#1;
		chk(reset_active, 0);
		@(posedge mclk);
		src_req <= '0;
		// locked write is dropped
		wr(8'hFF, 8'h00, 8'h00, 1'b1);
		chk(src_enable, 8'hFB);
		wr(8'hFF, 8'h00, 8'h00, 1'b0);
		chk(src_enable, 8'hFF);
		$display("test mask and lock done");
		tally_and_finish();
	end
endmodule : tb
